// ---- core/hhp_dma_chan.sv ----
// Block DMA request generation for one channel, receive and transmit.
`timescale 1ns/100ps
`default_nettype none
module hhp_dma_chan
  import hhp_pkg::*;
#(
  parameter int unsigned CNT_W = TX_CNT_W
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             srst,
  // Receive side
  input  wire logic             rx_blk_go,
  input  wire logic [1:0]       rx_blk_code,
  input  wire logic             rx_pop,
  output logic                  rx_req,
  // Transmit side
  input  wire logic             tx_room,
  input  wire logic             tx_cnt_load,
  input  wire logic [CNT_W-1:0] tx_cnt_value,
  input  wire logic             tx_push,
  output logic                  tx_req,
  output logic [CNT_W-1:0]      tx_left
);

  if (CNT_W < BLK_W) begin : g_bad_cnt
    $error("CNT_W must hold at least one full block");
  end

  hhp_dma_e         rx_st_ff;
  hhp_dma_e         tx_st_ff;
  logic [5:0]       rx_left_ff;
  logic [5:0]       tx_blk_ff;
  logic [CNT_W-1:0] tx_total_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Receive block: the request stands until the block's last byte is read.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_st_ff   <= HHP_IDLE;
      rx_left_ff <= 6'h00;
    end else begin
      case (rx_st_ff)
        HHP_IDLE: begin
          if (rx_blk_go) begin
            rx_st_ff   <= HHP_BURST;
            rx_left_ff <= hhp_rx_blk_bytes(rx_blk_code);
          end
        end
        HHP_BURST: begin
          if (rx_pop) begin
            rx_left_ff <= rx_left_ff - 6'h01;
            if (rx_left_ff == 6'h01) begin
              rx_st_ff <= HHP_IDLE;
            end
          end
        end
        default: rx_st_ff <= HHP_IDLE;
      endcase
    end
  end

  assign rx_req = (rx_st_ff == HHP_BURST);

  ////////////////////////////////////////////////////////////////////////////
  // Transmit byte count, counted down by every accepted push.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_total_ff <= '0;
    end else if (tx_cnt_load) begin
      tx_total_ff <= tx_cnt_value;
    end else if (tx_push && tx_st_ff == HHP_BURST && tx_total_ff != '0) begin
      tx_total_ff <= tx_total_ff - CNT_W'(1);
    end
  end

  // Blocks of full size, then one remainder block, then silence.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_st_ff  <= HHP_IDLE;
      tx_blk_ff <= 6'h00;
    end else begin
      case (tx_st_ff)
        HHP_IDLE: begin
          if (tx_room && tx_total_ff != '0 && !tx_cnt_load) begin
            tx_st_ff <= HHP_BURST;
            if (tx_total_ff > CNT_W'(TX_BLK_BYTES)) begin
              tx_blk_ff <= TX_BLK_BYTES;
            end else begin
              tx_blk_ff <= tx_total_ff[5:0];
            end
          end
        end
        HHP_BURST: begin
          if (tx_push) begin
            tx_blk_ff <= tx_blk_ff - 6'h01;
            if (tx_blk_ff == 6'h01) begin
              tx_st_ff <= HHP_IDLE;
            end
          end
        end
        default: tx_st_ff <= HHP_IDLE;
      endcase
    end
  end

  assign tx_req  = (tx_st_ff == HHP_BURST);
  assign tx_left = tx_total_ff;

  ////////////////////////////////////////////////////////////////////////////
  a_rx_last_drop: assert property (@(posedge ref_clk) disable iff (srst)
    rx_req && rx_pop && rx_left_ff == 6'h01 |=> !rx_req)
    else $error("receive request not dropped after last read");

  a_rx_block_len: assert property (@(posedge ref_clk) disable iff (srst)
    !rx_req && rx_blk_go |=> rx_req && rx_left_ff == hhp_rx_blk_bytes($past(rx_blk_code)))
    else $error("receive block not started with its size");

  a_tx_block_max: assert property (@(posedge ref_clk) disable iff (srst)
    tx_req |-> tx_blk_ff <= TX_BLK_BYTES && tx_blk_ff != 6'h00
      && CNT_W'(tx_blk_ff) <= tx_total_ff)
    else $error("transmit block exceeds size or remaining count");

  a_tx_count_stop: assert property (@(posedge ref_clk) disable iff (srst)
    tx_left == '0 && !tx_req && !tx_cnt_load |=> !tx_req)
    else $error("transmit request after byte count reached");

endmodule
`default_nettype wire

// ---- core/hhp_port.sv ----
// Processor and DMA port of a dual-channel serial link controller.
`timescale 1ns/100ps
`default_nettype none
module hhp_port
  import hhp_pkg::*;
#(
  parameter int unsigned CNT_W = TX_CNT_W
) (
  // Clock and reset
  input  wire logic                              ref_clk,
  input  wire logic                              srst,
  // Host bus pins
  input  wire logic                              bus_style_strap,
  input  wire logic                              ale_strobe_style,
  input  wire logic                              cs_n,
  input  wire logic                              read_strobe_control,
  input  wire logic                              write_or_rw,
  input  wire logic [ADDR_W-1:0]                 register_address_inputs,
  input  wire logic [DATA_W-1:0]                 data_in,
  output logic [DATA_W-1:0]                      data_out,
  output logic                                   data_oe,
  // Interrupt pin, open drain
  output logic                                   irq_out,
  output logic                                   irq_oe,
  // DMA pins
  input  wire logic                              dma_ack_chan_a_n,
  input  wire logic                              dma_ack_chan_b_n,
  output logic                                   rx_dma_request_a,
  output logic                                   rx_dma_request_b,
  output logic                                   tx_dma_request_a,
  output logic                                   tx_dma_request_b,
  // Internal register access
  output logic [ADDR_W-1:0]                      reg_addr,
  output logic [DATA_W-1:0]                      wr_data,
  output logic                                   reg_wr,
  output logic                                   reg_rd,
  input  wire logic [DATA_W-1:0]                 reg_rdata,
  // Interrupt causes
  input  wire logic                              irq_event_std,
  input  wire logic                              irq_event_ext,
  // FIFO side, one entry per channel
  input  wire logic [NUM_CHAN-1:0][DATA_W-1:0]   rx_top_data,
  output logic [NUM_CHAN-1:0]                    rx_pop,
  output logic [NUM_CHAN-1:0]                    tx_push,
  input  wire logic [NUM_CHAN-1:0]               rx_blk_go,
  input  wire logic [NUM_CHAN-1:0][1:0]          rx_blk_code,
  input  wire logic [NUM_CHAN-1:0]               tx_room,
  input  wire logic [NUM_CHAN-1:0]               tx_cnt_load,
  input  wire logic [CNT_W-1:0]                  tx_cnt_value,
  output logic [NUM_CHAN-1:0][CNT_W-1:0]         tx_left
);

  if (CNT_W < BLK_W || NUM_CHAN != 2) begin : g_bad_param
    $error("unsupported parameter value");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser. A bit changes once stages two and three agree, which
  // rejects single-sample glitches at the cost of one extra cycle of delay.
  logic [PIN_W-1:0] raw_pins;
  logic [PIN_W-1:0] sync1_ff;
  logic [PIN_W-1:0] sync2_ff;
  logic [PIN_W-1:0] sync3_ff;
  logic [PIN_W-1:0] flt_ff;
  hhp_pins_s        pins;
  logic [ADDR_W-1:0] pin_addr;
  logic [DATA_W-1:0] pin_data;

  assign raw_pins = {bus_style_strap, ale_strobe_style, cs_n,
                     read_strobe_control, write_or_rw,
                     dma_ack_chan_b_n, dma_ack_chan_a_n,
                     register_address_inputs, data_in};

  // Reset preloads every stage with the pin levels, so the straps and the
  // idle strobe levels are settled after one reset cycle and no false edge
  // follows the release.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync1_ff <= raw_pins;
      sync2_ff <= raw_pins;
      sync3_ff <= raw_pins;
      flt_ff   <= raw_pins;
    end else begin
      sync1_ff <= raw_pins;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      flt_ff   <= (sync2_ff & sync3_ff) | (flt_ff & (sync2_ff | sync3_ff));
    end
  end

  assign {pins, pin_addr, pin_data} = flt_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture. The strap is taken while reset is held; it needs two
  // reset cycles, one to preload the synchroniser and one to capture.
  logic bus_style_ff;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bus_style_ff <= pins.bus_style_strap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe decode and target selection.
  logic              sep_mode;
  logic              mot_act;
  logic              rd_act;
  logic              wr_act;
  logic              dma_a;
  logic              dma_b;
  logic              dma_any;
  logic              sel_reg;
  logic [ADDR_W-1:0] addr_lat_ff;
  logic [ADDR_W-1:0] eff_addr;
  logic              rd_prev_ff;
  logic              wr_prev_ff;
  logic              rd_start;
  logic              wr_end;

  assign sep_mode = !bus_style_ff;
  assign mot_act  = pins.ale_strobe_style ? !pins.read_strobe_control
                                          : pins.read_strobe_control;
  assign rd_act   = sep_mode ? !pins.read_strobe_control
                             : (mot_act && pins.write_or_rw);
  assign wr_act   = sep_mode ? !pins.write_or_rw
                             : (mot_act && !pins.write_or_rw);
  assign dma_a    = !pins.dma_ack_n[CHAN_A];
  assign dma_b    = !pins.dma_ack_n[CHAN_B] && !dma_a;
  assign dma_any  = dma_a || dma_b;
  assign sel_reg  = !pins.cs_n && !dma_any;
  assign rd_start = rd_act && !rd_prev_ff;
  assign wr_end   = !wr_act && wr_prev_ff;

  // Address latch is transparent while the latch strobe is high.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      addr_lat_ff <= '0;
    end else if (sep_mode && pins.ale_strobe_style) begin
      addr_lat_ff <= pin_addr;
    end
  end

  assign eff_addr = (sep_mode && !pins.ale_strobe_style) ? addr_lat_ff
                                                         : pin_addr;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_prev_ff <= 1'b0;
      wr_prev_ff <= 1'b0;
    end else begin
      rd_prev_ff <= rd_act;
      wr_prev_ff <= wr_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write path: data and target are tracked during the strobe and acted on
  // at its trailing edge, where the host guarantees valid data.
  logic [DATA_W-1:0] wr_hold_ff;
  logic [ADDR_W-1:0] wr_addr_ff;
  logic [2:0]        wr_tgt_ff;
  logic [ADDR_W-1:0] reg_addr_ff;
  logic [DATA_W-1:0] wr_data_ff;
  logic              reg_wr_ff;
  logic              reg_rd_ff;
  logic [1:0]        rx_pop_ff;
  logic [1:0]        tx_push_ff;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_hold_ff <= '0;
      wr_addr_ff <= '0;
      wr_tgt_ff  <= 3'h0;
    end else if (wr_act) begin
      wr_hold_ff <= pin_data;
      wr_addr_ff <= eff_addr;
      wr_tgt_ff  <= {dma_b, dma_a, sel_reg};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_wr_ff  <= 1'b0;
      tx_push_ff <= 2'h0;
      wr_data_ff <= '0;
    end else begin
      reg_wr_ff  <= wr_end && wr_tgt_ff[0];
      tx_push_ff <= wr_end ? wr_tgt_ff[2:1] : 2'h0;
      if (wr_end) begin
        wr_data_ff <= wr_hold_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: register data arrives one cycle after the read pulse; FIFO
  // data is taken at the leading edge together with the pop.
  logic              rd_busy_ff;
  logic [DATA_W-1:0] data_out_ff;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rd_ff <= 1'b0;
      rx_pop_ff <= 2'h0;
    end else begin
      reg_rd_ff <= rd_start && sel_reg;
      rx_pop_ff <= rd_start ? {dma_b, dma_a} : 2'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_addr_ff <= '0;
    end else if ((rd_start && sel_reg) || (wr_end && wr_tgt_ff[0])) begin
      reg_addr_ff <= rd_start ? eff_addr : wr_addr_ff;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_busy_ff  <= 1'b0;
      data_out_ff <= '0;
    end else begin
      if (rd_start) begin
        rd_busy_ff <= sel_reg || dma_any;
      end else if (!rd_act) begin
        rd_busy_ff <= 1'b0;
      end
      if (rd_start && dma_any) begin
        data_out_ff <= rx_top_data[dma_b ? CHAN_B : CHAN_A];
      end else if (reg_rd_ff) begin
        data_out_ff <= reg_rdata;
      end
    end
  end

  assign data_out = data_out_ff;
  assign data_oe  = rd_busy_ff && rd_act;
  assign reg_addr = reg_addr_ff;
  assign wr_data  = wr_data_ff;
  assign reg_wr   = reg_wr_ff;
  assign reg_rd   = reg_rd_ff;
  assign rx_pop   = rx_pop_ff;
  assign tx_push  = tx_push_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt: each cause is held until its status register is read; a new
  // event in the read cycle wins so that it is never lost.
  logic pend_std_ff;
  logic pend_ext_ff;
  logic rd_std;
  logic rd_ext;

  assign rd_std = reg_rd_ff && reg_addr_ff == IRQ_STAT_ADDR;
  assign rd_ext = reg_rd_ff && reg_addr_ff == EXT_IRQ_STAT_ADDR;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend_std_ff <= 1'b0;
      pend_ext_ff <= 1'b0;
    end else begin
      pend_std_ff <= irq_event_std || (pend_std_ff && !rd_std);
      pend_ext_ff <= irq_event_ext || (pend_ext_ff && !rd_ext);
    end
  end

  assign irq_out = 1'b0;
  assign irq_oe  = pend_std_ff || pend_ext_ff;

  ////////////////////////////////////////////////////////////////////////////
  // DMA request engines, one per channel.
  logic [NUM_CHAN-1:0] rx_req;
  logic [NUM_CHAN-1:0] tx_req;

  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
    hhp_dma_chan #(
      .CNT_W (CNT_W)
    ) u_chan (
      .ref_clk      (ref_clk),
      .srst         (srst),
      .rx_blk_go    (rx_blk_go[ch]),
      .rx_blk_code  (rx_blk_code[ch]),
      .rx_pop       (rx_pop_ff[ch]),
      .rx_req       (rx_req[ch]),
      .tx_room      (tx_room[ch]),
      .tx_cnt_load  (tx_cnt_load[ch]),
      .tx_cnt_value (tx_cnt_value),
      .tx_push      (tx_push_ff[ch]),
      .tx_req       (tx_req[ch]),
      .tx_left      (tx_left[ch])
    );
  end

  assign rx_dma_request_a = rx_req[CHAN_A];
  assign rx_dma_request_b = rx_req[CHAN_B];
  assign tx_dma_request_a = tx_req[CHAN_A];
  assign tx_dma_request_b = tx_req[CHAN_B];

  ////////////////////////////////////////////////////////////////////////////
  a_strap_fixed: assert property (@(posedge ref_clk) disable iff (srst)
    $stable(bus_style_ff))
    else $error("bus style changed outside reset");

  a_reg_read: assert property (@(posedge ref_clk) disable iff (srst)
    rd_start && sel_reg |=> reg_rd && reg_addr == $past(eff_addr)
      ##1 data_out == $past(reg_rdata))
    else $error("register read not issued or data not returned");

  a_reg_write: assert property (@(posedge ref_clk) disable iff (srst)
    wr_act && sel_reg ##1 !wr_act |=> reg_wr && wr_data == $past(wr_hold_ff))
    else $error("register write not issued at strobe end");

  a_dma_no_reg: assert property (@(posedge ref_clk) disable iff (srst)
    rd_start && dma_any |=> !reg_rd && rx_pop != 2'h0)
    else $error("acknowledged read touched register space");

  a_dma_push: assert property (@(posedge ref_clk) disable iff (srst)
    wr_act && dma_a ##1 !wr_act |=> tx_push[CHAN_A] && !reg_wr)
    else $error("acknowledged write did not push");

  a_addr_latch: assert property (@(posedge ref_clk) disable iff (srst)
    sep_mode && pins.ale_strobe_style ##1 !pins.ale_strobe_style
      |-> eff_addr == $past(pin_addr))
    else $error("address not held at latch falling edge");

  a_irq_held: assert property (@(posedge ref_clk) disable iff (srst)
    pend_std_ff && !rd_std |=> irq_oe)
    else $error("interrupt released before status read");

  a_irq_drive: assert property (@(posedge ref_clk) disable iff (srst)
    irq_event_ext |=> irq_oe && !irq_out)
    else $error("interrupt pin not pulled low after event");

endmodule
`default_nettype wire

// ---- include/hhp_pkg.sv ----
// Shared constants, types and helpers for the serial controller host port.
package hhp_pkg;

  localparam int unsigned ADDR_W      = 7;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned NUM_CHAN    = 2;
  localparam int unsigned TX_CNT_W    = 16;
  localparam int unsigned BLK_W       = 6;

  // Block sizes in bytes.
  localparam logic [5:0]  TX_BLK_BYTES = 6'h20;
  localparam logic [5:0]  RX_BLK_32    = 6'h20;
  localparam logic [5:0]  RX_BLK_16    = 6'h10;
  localparam logic [5:0]  RX_BLK_8     = 6'h08;
  localparam logic [5:0]  RX_BLK_4     = 6'h04;

  // Register indices of the two interrupt status registers.
  localparam logic [6:0]  IRQ_STAT_ADDR     = 7'h20;
  localparam logic [6:0]  EXT_IRQ_STAT_ADDR = 7'h24;

  // Channel index of each acknowledge.
  localparam int unsigned CHAN_A = 0;
  localparam int unsigned CHAN_B = 1;

  typedef enum logic [1:0] {
    HHP_IDLE  = 2'h0,
    HHP_BURST = 2'h1
  } hhp_dma_e;

  // Control pins in the order they enter the synchroniser.
  typedef struct packed {
    logic       bus_style_strap;
    logic       ale_strobe_style;
    logic       cs_n;
    logic       read_strobe_control;
    logic       write_or_rw;
    logic [1:0] dma_ack_n;
  } hhp_pins_s;

  localparam int unsigned PIN_W = $bits(hhp_pins_s) + ADDR_W + DATA_W;

  function automatic logic [5:0] hhp_rx_blk_bytes(input logic [1:0] code);
    logic [5:0] n;
    n = RX_BLK_32;
    case (code)
      2'h0: n = RX_BLK_32;
      2'h1: n = RX_BLK_16;
      2'h2: n = RX_BLK_8;
      default: n = RX_BLK_4;
    endcase
    return n;
  endfunction

endpackage

// ---- tb/hhp_host_model.sv ----
// Host processor and DMA controller model driving the port pins.
`timescale 1ns/100ps
`default_nettype none
module hhp_host_model
  import hhp_pkg::*;
#(
  parameter int STB = 8
) (
  // Clock
  input  wire logic              ref_clk,
  // Host pins
  output logic                   cs_n,
  output logic                   read_strobe_control,
  output logic                   write_or_rw,
  output logic [ADDR_W-1:0]      register_address_inputs,
  output logic [DATA_W-1:0]      data_in,
  output logic                   dma_ack_chan_a_n,
  output logic                   dma_ack_chan_b_n,
  // Device side of the data bus
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic              data_oe
);
  logic [DATA_W-1:0] host_d = 8'h00;
  // A released bus shows the inverse of its last value, never a held copy.
  assign data_in = data_oe ? data_out : host_d;
  initial begin
    cs_n = 1'b1;
    read_strobe_control = 1'b1;
    write_or_rw = 1'b1;
    register_address_inputs = 7'h00;
    dma_ack_chan_a_n = 1'b1;
    dma_ack_chan_b_n = 1'b1;
  end
  //////////////////////////////////////////////////////////////////////////
  // Strobes last STB cycles and are followed by STB idle cycles, well clear
  // of the glitch filter; qualifiers are held over the whole access.
  task automatic access(input logic rd, input logic sel,
                        input logic [1:0] ack, input logic [6:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    cs_n <= ~sel;
    dma_ack_chan_a_n <= ~ack[0];
    dma_ack_chan_b_n <= ~ack[1];
    register_address_inputs <= a;
    host_d <= d;
    read_strobe_control <= ~rd;
    write_or_rw <= rd;
    repeat (STB) @(posedge ref_clk);
    q = data_in;
    read_strobe_control <= 1'b1;
    write_or_rw <= 1'b1;
    repeat (STB) @(posedge ref_clk);
    cs_n <= 1'b1;
    dma_ack_chan_a_n <= 1'b1;
    dma_ack_chan_b_n <= 1'b1;
    register_address_inputs <= ~a;
    host_d <= ~d;
  endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the host port with a queue-based reference.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import hhp_pkg::*;
  logic            ref_clk = 1'b0;
  logic            srst = 1'b1;
  logic            bus_style_strap = 1'b0;
  logic            ale_strobe_style = 1'b1;
  logic            cs_n, read_strobe_control, write_or_rw, data_oe;
  logic            irq_out, irq_oe, irq_line, reg_wr, reg_rd;
  logic            dma_ack_chan_a_n, dma_ack_chan_b_n;
  logic            rx_dma_request_a, rx_dma_request_b;
  logic            tx_dma_request_a, tx_dma_request_b;
  logic            irq_event_std = 1'b0;
  logic            irq_event_ext = 1'b0;
  logic [6:0]      register_address_inputs, reg_addr;
  logic [7:0]      data_in, data_out, wr_data, reg_rdata, q, b, exp_push;
  logic [1:0][7:0] rx_top_data = '0;
  logic [1:0]      rx_pop, tx_push;
  logic [1:0]      rx_blk_go = '0;
  logic [1:0]      tx_room = '0;
  logic [1:0]      tx_cnt_load = '0;
  logic [1:0][1:0] rx_blk_code = '0;
  logic [15:0]     tx_cnt_value = '0;
  logic [1:0][15:0] tx_left;
  logic [31:0]     lfsr = 32'hb14c;
  logic [14:0]     exp_wr[$];
  logic [6:0]      exp_rd[$];
  int              n_errors = 0;
  int              n_checks = 0;
  int              n_pop = 0;
  int              n_push = 0;

  always #12.5 ref_clk = ~ref_clk;
  // Stand-in register file: contents are a fixed mix of the address.
  assign reg_rdata = {1'b0, reg_addr} ^ 8'h5a;
  assign irq_line = irq_oe ? irq_out : 1'b1;

  hhp_port i_hhp_port (.ref_clk, .srst, .bus_style_strap, .ale_strobe_style,
    .cs_n, .read_strobe_control, .write_or_rw, .register_address_inputs,
    .data_in, .data_out, .data_oe, .irq_out, .irq_oe, .dma_ack_chan_a_n,
    .dma_ack_chan_b_n, .rx_dma_request_a, .rx_dma_request_b,
    .tx_dma_request_a, .tx_dma_request_b, .reg_addr, .wr_data, .reg_wr,
    .reg_rd, .reg_rdata, .irq_event_std, .irq_event_ext, .rx_top_data,
    .rx_pop, .tx_push, .rx_blk_go, .rx_blk_code, .tx_room, .tx_cnt_load,
    .tx_cnt_value, .tx_left);
  hhp_host_model i_hhp_host_model (.ref_clk, .cs_n, .read_strobe_control,
    .write_or_rw, .register_address_inputs, .data_in, .dma_ack_chan_a_n,
    .dma_ack_chan_b_n, .data_out, .data_oe);

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Register accesses are checked against the queues as they appear; push data against exp_push, pops only counted.
  always @(posedge ref_clk) if (srst === 1'b0) begin
    if (reg_wr === 1'b1) begin
      if (exp_wr.size() == 0) chk("stray write", 1, 0);
      else chk("write", {reg_addr, wr_data}, exp_wr.pop_front());
    end
    if (reg_rd === 1'b1) begin
      if (exp_rd.size() == 0) chk("stray read", 1, 0);
      else chk("read address", reg_addr, exp_rd.pop_front());
    end
    if (rx_pop[0] === 1'b1) n_pop++;
    if (tx_push[1] === 1'b1) begin
      n_push++;
      chk("push data", wr_data, exp_push);
    end
    if (rx_pop[1] !== 1'b0 || tx_push[0] !== 1'b0) chk("fifo", 1, 0);
  end
  // Limit is about fifteen times the expected run length.
  initial begin
    repeat (30000) @(posedge ref_clk);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_step(lfsr);
      exp_wr.push_back({lfsr[6:0], lfsr[15:8]});
      i_hhp_host_model.access(0, 1, 0, lfsr[6:0], lfsr[15:8], q);
      exp_rd.push_back(lfsr[6:0]);
      i_hhp_host_model.access(1, 1, 0, lfsr[6:0], lfsr[23:16], q);
      chk("read data", q, {1'b0, lfsr[6:0]} ^ 8'h5a);
    end
    i_hhp_host_model.access(0, 0, 0, 7'h11, 8'h3c, q);
    chk("pending", exp_wr.size() + exp_rd.size(), 0);
    $display("register test done");
    irq_event_std <= 1'b1;
    irq_event_ext <= 1'b1;
    @(posedge ref_clk);
    irq_event_std <= 1'b0;
    irq_event_ext <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("irq set", irq_line, 0);
    exp_rd.push_back(IRQ_STAT_ADDR);
    i_hhp_host_model.access(1, 1, 0, IRQ_STAT_ADDR, 8'h00, q);
    chk("irq held", irq_line, 0);
    exp_rd.push_back(EXT_IRQ_STAT_ADDR);
    i_hhp_host_model.access(1, 1, 0, EXT_IRQ_STAT_ADDR, 8'h00, q);
    chk("irq released", irq_line, 1);
    $display("interrupt test done");
    for (int c = 0; c < 4; c++) begin
      rx_blk_code[0] <= c[1:0];
      rx_blk_go[0] <= 1'b1;
      @(posedge ref_clk);
      rx_blk_go[0] <= 1'b0;
      n_pop = 0;
      repeat (2) @(posedge ref_clk);
      for (int i = 0; i < (32 >> c); i++) begin
        lfsr = lfsr_step(lfsr);
        b = lfsr[7:0];
        rx_top_data[0] <= b;
        chk("rx request", rx_dma_request_a, 1);
        i_hhp_host_model.access(1, lfsr[8], 2'b01, lfsr[14:8], 8'h00, q);
        chk("rx data", q, b);
      end
      chk("rx drop", rx_dma_request_a, 0);
      chk("rx pops", n_pop, 32 >> c);
    end
    $display("receive dma test done");
    tx_cnt_value <= 16'h0028;
    tx_cnt_load[1] <= 1'b1;
    @(posedge ref_clk);
    tx_cnt_load[1] <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      tx_room[1] <= 1'b1;
      for (int w = 0; w < 20 && tx_dma_request_b !== 1'b1; w++)
        @(posedge ref_clk);
      tx_room[1] <= 1'b0;
      chk("tx request", tx_dma_request_b, 1);
      n_push = 0;
      for (int i = 0; i < (k ? 8 : 32); i++) begin
        lfsr = lfsr_step(lfsr);
        exp_push = lfsr[7:0];
        i_hhp_host_model.access(0, lfsr[8], 2'b10, lfsr[14:8], exp_push, q);
      end
      chk("tx drop", tx_dma_request_b, 0);
      chk("tx pushes", n_push, k ? 8 : 32);
      chk("tx left", tx_left[1], k ? 0 : 8);
    end
    tx_room[1] <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk("tx stop", tx_dma_request_b, 0);
    chk("idle", {rx_dma_request_b, tx_dma_request_a}, 0);
    $display("transmit dma test done");
    summarize();
  end
endmodule
`default_nettype wire
